// >>> design/mac_port_params.svh
/*
 * Constants for the MAC port receive front end and transmit timing.
 * Assumes the system clock runs at the rate given by REF_CLK_MHZ.
 */
`ifndef MAC_PORT_PARAMS_SVH
`define MAC_PORT_PARAMS_SVH

// System clock and generated MII transmit clock, in MHz
`define REF_CLK_MHZ 200
`define MII_TX_CLK_MHZ 25
// System cycles per half period of the generated transmit clock
`define MII_TX_HALF_CYCLES (`REF_CLK_MHZ / (2 * `MII_TX_CLK_MHZ))
`define MII_TX_DIV_MAX 3'(`MII_TX_HALF_CYCLES - 1)
`define MII_TX_DIV_RESET 3'h0

// Receive data nibble that marks a false carrier while valid is low
`define FALSE_CARRIER_CODE 4'he

// Receive word buffer
`define RX_FIFO_DEPTH 4

`endif

// >>> design/mac_port_pkg.sv
/*
 * Types shared by the MAC port front end, its checker and its bench.
 * Assumes mac_port_params.svh supplies all numeric constants.
 */
package mac_port_pkg;

    typedef enum logic [1:0] {MODE_MII, MODE_RMII, MODE_TBI} port_mode_type;

    typedef enum logic {TX_IDLE, TX_FRAME} tx_state_type;

    typedef struct packed {
        logic tbi_code;
        logic data_valid;
        logic data_error;
        logic false_carrier;
        logic [9:0] code_a;
        logic [9:0] code_b;
    } rx_word_type;

endpackage : mac_port_pkg

// >>> design/async_word_fifo.sv
/*
 * Dual-clock word buffer with gray-coded pointers.
 * Assumes each side has its own reset released synchronously to its clock;
 * depth must be a power of two.
 */
`timescale 1ns/1ps
`include "mac_port_params.svh"

module async_word_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = `RX_FIFO_DEPTH
) (
    input wire logic wr_clk,
    input wire logic wr_rst,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic rd_clk,
    input wire logic rd_rst,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [WIDTH-1:0] rd_data
);

    localparam int AW = $clog2(DEPTH);

    function automatic logic [AW:0] bin_to_gray(input logic [AW:0] bin);
        bin_to_gray = bin ^ (bin >> 1);
    endfunction : bin_to_gray

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_bin;
    logic [AW:0] next_wr_bin;
    logic [AW:0] wr_gray;
    logic [AW:0] rd_bin;
    logic [AW:0] next_rd_bin;
    logic [AW:0] rd_gray;
    logic [AW:0] rd_gray_s0;
    logic [AW:0] rd_gray_s1;
    logic [AW:0] wr_gray_s0;
    logic [AW:0] wr_gray_s1;

    ////////////////////////////////////////////////////////////////////////////////
    // Write side

    assign wr_ready = (wr_gray != {~rd_gray_s1[AW:AW-1], rd_gray_s1[AW-2:0]});

    always_comb
    begin
        next_wr_bin = wr_bin;
        if (wr_valid && wr_ready)
        begin
            next_wr_bin = wr_bin + 1'b1;
        end
    end

    always_ff @(posedge wr_clk or posedge wr_rst)
    begin
        if (wr_rst)
        begin
            wr_bin <= '0;
            wr_gray <= '0;
            rd_gray_s0 <= '0;
            rd_gray_s1 <= '0;
        end
        else
        begin
            wr_bin <= next_wr_bin;
            wr_gray <= bin_to_gray(next_wr_bin);
            rd_gray_s0 <= rd_gray;
            rd_gray_s1 <= rd_gray_s0;
        end
    end

    // Storage carries data only, so it needs no reset
    always_ff @(posedge wr_clk)
    begin
        if (wr_valid && wr_ready)
        begin
            mem[wr_bin[AW-1:0]] <= wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read side

    assign rd_valid = (rd_gray != wr_gray_s1);
    assign rd_data = mem[rd_bin[AW-1:0]];

    always_comb
    begin
        next_rd_bin = rd_bin;
        if (rd_valid && rd_ready)
        begin
            next_rd_bin = rd_bin + 1'b1;
        end
    end

    always_ff @(posedge rd_clk or posedge rd_rst)
    begin
        if (rd_rst)
        begin
            rd_bin <= '0;
            rd_gray <= '0;
            wr_gray_s0 <= '0;
            wr_gray_s1 <= '0;
        end
        else
        begin
            rd_bin <= next_rd_bin;
            rd_gray <= bin_to_gray(next_rd_bin);
            wr_gray_s0 <= wr_gray;
            wr_gray_s1 <= wr_gray_s0;
        end
    end

endmodule : async_word_fifo

// >>> design/mac_port_front.sv
/*
 * MAC port pin front end: receive capture for MII, RMII and TBI, carrier
 * sense handling, MII transmit clock direction and transmit enable timing.
 * Assumes port_mode and phy_emulation are static while traffic flows and
 * that the TBI byte clocks are phase locked half a period apart.
 */
// Operation
// - Receive error flags an error, counted as one only while receive valid is high.
// - In MII, error high with valid low and the false carrier code marks a false carrier.
// - In TBI the error pin is code bit 9, taken on both byte clocks.
// - Carrier sense is async, active high, asserted while transmit or receive is busy.
// - In TBI the carrier pin is signal detect with the same role.
// - Transmit clock pin is used only in MII and runs at 25 MHz.
// - Transmit clock is input as MAC, generated output in PHY emulation.
// - RMII carrier valid is high while receive medium busy, taken on reference clock.
// - Transmit enable rises on a transmit clock edge and holds to frame end.
`timescale 1ns/1ps
`include "mac_port_params.svh"

module mac_port_front
    import mac_port_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire port_mode_type port_mode,
    input wire logic phy_emulation,
    input wire logic link_rx_clock,
    input wire logic tbi_rx_byte_clock_b,
    input wire logic [7:0] rx_data_bus,
    input wire logic rx_valid_line,
    input wire logic rx_error_line,
    input wire logic carrier_sense_in,
    output logic carrier_sense_out,
    output logic carrier_sense_oe,
    input wire logic mii_transmit_clock_in,
    output logic mii_transmit_clock_out,
    output logic mii_transmit_clock_oe,
    input wire logic tx_frame_request,
    output logic tx_frame_enable,
    output logic tx_clock_rise,
    output logic carrier_sensed,
    output rx_word_type rx_word,
    output logic rx_word_valid,
    input wire logic rx_word_ready,
    output logic rx_overrun
);

    localparam int WORD_W = $bits(rx_word_type);

    // Pin synchronisers: bit 0 carrier, bit 1 MII transmit clock, bit 2 RMII clock
    logic [2:0] pin_raw;
    logic [2:0] pin_s0;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_level;
    logic [2:0] next_pin_level;
    logic [2:0] pin_rise;

    logic [2:0] tx_div;
    logic [2:0] next_tx_div;
    logic gen_clk;
    logic next_gen_clk;
    logic gen_rise;
    logic tx_tick;
    tx_state_type tx_state;
    tx_state_type next_tx_state;

    logic rx_busy_s0;
    logic rx_busy_s1;
    logic ovr_s0;
    logic ovr_s1;
    logic ovr_s2;
    logic next_cs_out;
    logic next_carrier_sensed;

    // Link domain
    logic link_rst_s0;
    logic link_rst;
    logic [1:0] mode_s0;
    logic [1:0] mode_s1;
    port_mode_type link_mode;
    logic [9:0] code_b_raw;
    logic [9:0] code_b_link;
    rx_word_type sample;
    logic push;
    rx_word_type held;
    rx_word_type next_held;
    logic held_valid;
    logic next_held_valid;
    logic ovr_toggle;
    logic next_ovr_toggle;
    logic rx_busy;
    logic next_rx_busy;
    logic fifo_wr_ready;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin inputs into the system clock domain

    assign pin_raw = {link_rx_clock, mii_transmit_clock_in, carrier_sense_in};

    always_comb
    begin
        // A change counts once the second and third stages agree
        next_pin_level = (pin_s1 & pin_s2) | (pin_level & (pin_s1 | pin_s2));
        pin_rise = next_pin_level & ~pin_level;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_s0 <= 3'h0;
            pin_s1 <= 3'h0;
            pin_s2 <= 3'h0;
            pin_level <= 3'h0;
        end
        else
        begin
            pin_s0 <= pin_raw;
            pin_s1 <= pin_s0;
            pin_s2 <= pin_s1;
            pin_level <= next_pin_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit clock generation and transmit enable timing

    always_comb
    begin
        next_tx_div = tx_div + 3'h1;
        next_gen_clk = gen_clk;
        gen_rise = 1'b0;
        if (tx_div == `MII_TX_DIV_MAX)
        begin
            next_tx_div = `MII_TX_DIV_RESET;
            next_gen_clk = ~gen_clk;
            gen_rise = ~gen_clk;
        end
    end

    always_comb
    begin
        // Edges of an input clock are seen two to three cycles late
        unique case (port_mode)
            MODE_MII: tx_tick = phy_emulation ? gen_rise : pin_rise[1];
            MODE_RMII: tx_tick = pin_rise[2];
            MODE_TBI: tx_tick = 1'b0;
            default: tx_tick = 1'b0;
        endcase
        next_tx_state = tx_state;
        if (tx_tick)
        begin
            unique case (tx_state)
                TX_IDLE: if (tx_frame_request) next_tx_state = TX_FRAME;
                TX_FRAME: if (!tx_frame_request) next_tx_state = TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tx_div <= `MII_TX_DIV_RESET;
            gen_clk <= 1'b0;
            tx_state <= TX_IDLE;
        end
        else
        begin
            tx_div <= next_tx_div;
            gen_clk <= next_gen_clk;
            tx_state <= next_tx_state;
        end
    end

    assign tx_frame_enable = (tx_state == TX_FRAME);
    assign tx_clock_rise = tx_tick;
    assign mii_transmit_clock_out = gen_clk;
    assign mii_transmit_clock_oe = phy_emulation && (port_mode == MODE_MII);

    ////////////////////////////////////////////////////////////////////////////////
    // Carrier sense and signal detect

    always_comb
    begin
        next_cs_out = tx_frame_enable | rx_busy_s1;
        if (carrier_sense_oe)
        begin
            next_carrier_sensed = next_cs_out;
        end
        else if (port_mode == MODE_RMII)
        begin
            next_carrier_sensed = rx_busy_s1 | tx_frame_enable;
        end
        else
        begin
            // Signal detect in TBI takes the same path as carrier sense
            next_carrier_sensed = pin_level[0];
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_busy_s0 <= 1'b0;
            rx_busy_s1 <= 1'b0;
            ovr_s0 <= 1'b0;
            ovr_s1 <= 1'b0;
            ovr_s2 <= 1'b0;
            carrier_sense_out <= 1'b0;
            carrier_sensed <= 1'b0;
        end
        else
        begin
            rx_busy_s0 <= rx_busy;
            rx_busy_s1 <= rx_busy_s0;
            ovr_s0 <= ovr_toggle;
            ovr_s1 <= ovr_s0;
            ovr_s2 <= ovr_s1;
            carrier_sense_out <= next_cs_out;
            carrier_sensed <= next_carrier_sensed;
        end
    end

    assign carrier_sense_oe = phy_emulation && (port_mode != MODE_TBI);
    assign rx_overrun = ovr_s1 ^ ovr_s2;

    ////////////////////////////////////////////////////////////////////////////////
    // Link domain reset and mode

    always_ff @(posedge link_rx_clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            link_rst_s0 <= 1'b1;
            link_rst <= 1'b1;
        end
        else
        begin
            link_rst_s0 <= 1'b0;
            link_rst <= link_rst_s0;
        end
    end

    always_ff @(posedge link_rx_clock or posedge link_rst)
    begin
        if (link_rst)
        begin
            mode_s0 <= 2'h0;
            mode_s1 <= 2'h0;
        end
        else
        begin
            mode_s0 <= port_mode;
            mode_s1 <= mode_s0;
        end
    end

    assign link_mode = port_mode_type'(mode_s1);

    ////////////////////////////////////////////////////////////////////////////////
    // Receive capture

    // Second byte clock is phase locked to the first, so its code is safely
    // retimed half a period later without a full synchroniser
    always_ff @(posedge tbi_rx_byte_clock_b)
    begin
        code_b_raw <= {rx_error_line, rx_valid_line, rx_data_bus};
    end

    always_ff @(posedge link_rx_clock)
    begin
        code_b_link <= code_b_raw;
    end

    always_comb
    begin
        sample = '0;
        push = 1'b0;
        next_rx_busy = 1'b0;
        if (link_mode == MODE_TBI)
        begin
            sample.tbi_code = 1'b1;
            sample.code_a = {rx_error_line, rx_valid_line, rx_data_bus};
            sample.code_b = code_b_link;
            push = 1'b1;
        end
        else
        begin
            sample.code_a = {2'h0, rx_data_bus};
            sample.data_valid = rx_valid_line;
            sample.data_error = rx_valid_line & rx_error_line;
            sample.false_carrier = (link_mode == MODE_MII) & ~rx_valid_line & rx_error_line
                & (rx_data_bus[3:0] == `FALSE_CARRIER_CODE);
            push = rx_valid_line | rx_error_line;
            next_rx_busy = rx_valid_line;
        end
    end

    always_comb
    begin
        next_held = held;
        next_held_valid = held_valid;
        next_ovr_toggle = ovr_toggle;
        if (push)
        begin
            if (!held_valid || fifo_wr_ready)
            begin
                next_held = sample;
                next_held_valid = 1'b1;
            end
            else
            begin
                // Link cannot be stalled, so a word that finds no room is dropped
                next_ovr_toggle = ~ovr_toggle;
            end
        end
        else if (fifo_wr_ready)
        begin
            next_held_valid = 1'b0;
        end
    end

    always_ff @(posedge link_rx_clock or posedge link_rst)
    begin
        if (link_rst)
        begin
            held <= '0;
            held_valid <= 1'b0;
            ovr_toggle <= 1'b0;
            rx_busy <= 1'b0;
        end
        else
        begin
            held <= next_held;
            held_valid <= next_held_valid;
            ovr_toggle <= next_ovr_toggle;
            rx_busy <= next_rx_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receive buffer into the system clock domain

    async_word_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(`RX_FIFO_DEPTH)
    ) rx_buffer (
        .wr_clk(link_rx_clock),
        .wr_rst(link_rst),
        .wr_valid(held_valid),
        .wr_ready(fifo_wr_ready),
        .wr_data(held),
        .rd_clk(ref_clk),
        .rd_rst(sys_rst),
        .rd_valid(rx_word_valid),
        .rd_ready(rx_word_ready),
        .rd_data(rx_word)
    );

endmodule : mac_port_front

// >>> testbench/mac_port_front_properties.sv
/* Checker on the MAC port front end ports, bound to every instance.
   Assumes mode and role only change while reset is high. */
`timescale 1ns/1ps
module mac_port_front_properties
    import mac_port_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire port_mode_type port_mode,
    input wire logic phy_emulation,
    input wire logic carrier_sense_in,
    input wire logic carrier_sense_out,
    input wire logic carrier_sense_oe,
    input wire logic mii_transmit_clock_out,
    input wire logic mii_transmit_clock_oe,
    input wire logic tx_frame_request,
    input wire logic tx_frame_enable,
    input wire logic tx_clock_rise,
    input wire logic carrier_sensed,
    input wire rx_word_type rx_word,
    input wire logic rx_word_valid,
    input wire logic rx_word_ready
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    logic phy_mii;
    logic pin_crs;
    assign phy_mii = phy_emulation && port_mode == MODE_MII;
    // Carrier comes from the pin only where the far side drives it
    assign pin_crs = port_mode == MODE_TBI || (!phy_emulation && port_mode == MODE_MII);

    ////////////////////////////////////////////////////////////////////////////////
    AST_TXCLK_DIR: assert property (mii_transmit_clock_oe == phy_mii)
        else $error("transmit clock direction wrong");
    AST_CRS_DIR: assert property (
        carrier_sense_oe == (phy_emulation && port_mode != MODE_TBI))
        else $error("carrier pin direction wrong");
    AST_TXCLK_HALF: assert property (phy_mii && $changed(mii_transmit_clock_out) |=>
        $stable(mii_transmit_clock_out)[*3] ##1 $changed(mii_transmit_clock_out))
        else $error("transmit clock half period wrong");
    AST_TX_TICK_GEN: assert property (phy_mii && tx_clock_rise |=>
        $rose(mii_transmit_clock_out))
        else $error("tick without generated clock edge");
    AST_TXEN_ON_TICK: assert property ($changed(tx_frame_enable) |-> $past(tx_clock_rise))
        else $error("transmit enable moved off a clock edge");
    AST_TXEN_LOAD: assert property (tx_clock_rise && port_mode != MODE_TBI |=>
        tx_frame_enable == $past(tx_frame_request))
        else $error("transmit enable not taken at tick");
    AST_TBI_NO_TX: assert property (port_mode == MODE_TBI |-> !tx_frame_enable)
        else $error("transmit enable in ten-bit mode");
    AST_CRS_PIN: assert property (pin_crs && carrier_sense_in[*6] |-> carrier_sensed)
        else $error("carrier pin not seen");
    AST_CRS_TX: assert property (carrier_sense_oe && tx_frame_enable |=> carrier_sense_out)
        else $error("carrier not driven while sending");
    AST_RX_HOLD: assert property (rx_word_valid && !rx_word_ready |=>
        rx_word_valid && $stable(rx_word))
        else $error("receive word dropped before taken");
    AST_RX_FC: assert property (rx_word_valid && rx_word.false_carrier |->
        !rx_word.data_valid && port_mode == MODE_MII)
        else $error("false carrier with valid high");
    AST_RX_ERR: assert property (rx_word_valid && rx_word.data_error |->
        rx_word.data_valid)
        else $error("error flagged outside valid");
endmodule : mac_port_front_properties

bind mac_port_front mac_port_front_properties chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .port_mode(port_mode), .phy_emulation(phy_emulation), .carrier_sense_in(carrier_sense_in),
    .carrier_sense_out(carrier_sense_out), .carrier_sense_oe(carrier_sense_oe),
    .mii_transmit_clock_out(mii_transmit_clock_out), .mii_transmit_clock_oe(mii_transmit_clock_oe),
    .tx_frame_request(tx_frame_request), .tx_frame_enable(tx_frame_enable),
    .tx_clock_rise(tx_clock_rise), .carrier_sensed(carrier_sensed), .rx_word(rx_word),
    .rx_word_valid(rx_word_valid), .rx_word_ready(rx_word_ready));

// >>> testbench/phy_link_model.sv
/* Far side of the receive link: a PHY, or a MAC seen through PHY emulation.
   Assumes the bench calls send and idle and drives the carrier pin itself. */
`timescale 1ns/1ps
module phy_link_model (
    output logic link_rx_clock,
    output logic tbi_rx_byte_clock_b,
    output logic [7:0] rx_data_bus,
    output logic rx_valid_line,
    output logic rx_error_line,
    output logic mii_transmit_clock_in
);
    // Free running, so the link reset synchroniser always sees edges
    initial
    begin
        link_rx_clock = 1'b0;
        rx_data_bus = 8'h00;
        rx_valid_line = 1'b0;
        rx_error_line = 1'b0;
        #3;
        forever #32 link_rx_clock = ~link_rx_clock;
    end
    assign tbi_rx_byte_clock_b = ~link_rx_clock;

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        mii_transmit_clock_in = 1'b0;
        #7;
        forever #20 mii_transmit_clock_in = ~mii_transmit_clock_in;
    end
    task automatic send(input logic [7:0] d, input logic v, input logic e);
        @(posedge link_rx_clock);
        #1;
        rx_data_bus = d;
        rx_valid_line = v;
        rx_error_line = e;
    endtask : send
    // Idle data is not held: it flips so a stale value cannot pass for a sample
    task automatic idle();
        @(posedge link_rx_clock);
        #1;
        rx_valid_line = 1'b0;
        rx_error_line = 1'b0;
        rx_data_bus = ~rx_data_bus;
    endtask : idle
endmodule : phy_link_model

// >>> testbench/mac_port_front_tb.sv
/* Self-checking bench for the MAC port front end.
   Assumes the checker file is compiled with it and binds itself. */
`timescale 1ns/1ps
module mac_port_front_tb;
    import mac_port_pkg::*;
    logic ref_clk, sys_rst, phy_emulation, carrier_sense_in, tx_frame_request, rx_word_ready;
    logic link_rx_clock, tbi_rx_byte_clock_b, rx_valid_line, rx_error_line;
    logic mii_transmit_clock_in, carrier_sense_out, carrier_sense_oe, mii_transmit_clock_out;
    logic mii_transmit_clock_oe, tx_frame_enable, tx_clock_rise, carrier_sensed;
    logic rx_word_valid, rx_overrun;
    logic [7:0] rx_data_bus;
    port_mode_type port_mode;
    rx_word_type rx_word;
    rx_word_type got[$];
    rx_word_type want[$];
    int n_errors, n_compared, n_over, cycles;
    logic [31:0] seed = 32'h63d4;
    port_mode_type tm[4] = '{MODE_MII, MODE_MII, MODE_RMII, MODE_TBI};
    logic tp[4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    phy_link_model phy (.link_rx_clock(link_rx_clock), .tbi_rx_byte_clock_b(tbi_rx_byte_clock_b),
        .rx_data_bus(rx_data_bus), .rx_valid_line(rx_valid_line), .rx_error_line(rx_error_line),
        .mii_transmit_clock_in(mii_transmit_clock_in));
    mac_port_front dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .port_mode(port_mode),
        .phy_emulation(phy_emulation), .link_rx_clock(link_rx_clock),
        .tbi_rx_byte_clock_b(tbi_rx_byte_clock_b), .rx_data_bus(rx_data_bus),
        .rx_valid_line(rx_valid_line), .rx_error_line(rx_error_line),
        .carrier_sense_in(carrier_sense_in), .carrier_sense_out(carrier_sense_out),
        .carrier_sense_oe(carrier_sense_oe), .mii_transmit_clock_in(mii_transmit_clock_in),
        .mii_transmit_clock_out(mii_transmit_clock_out),
        .mii_transmit_clock_oe(mii_transmit_clock_oe), .tx_frame_request(tx_frame_request),
        .tx_frame_enable(tx_frame_enable), .tx_clock_rise(tx_clock_rise),
        .carrier_sensed(carrier_sensed), .rx_word(rx_word), .rx_word_valid(rx_word_valid),
        .rx_word_ready(rx_word_ready), .rx_overrun(rx_overrun));

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic rx_word_type exp_word(port_mode_type m, logic [7:0] d, logic v, logic e);
        return '{1'b0, v, v & e, (m == MODE_MII) & !v & e & (d[3:0] == 4'he), {2'b00, d}, 10'h000};
    endfunction : exp_word

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    // Reset spans link edges too, the link side has its own synchroniser
    task automatic start(input port_mode_type m, input logic phy_role);
        sys_rst = 1'b1;
        port_mode = m;
        phy_emulation = phy_role;
        repeat (3) @(posedge link_rx_clock);
        tick(1);
        sys_rst = 1'b0;
        repeat (8) @(posedge link_rx_clock);
        tick(1);
        got.delete();
        want.delete();
        n_over = 0;
    endtask : start

    task automatic send(input logic [7:0] d, input logic v, input logic e);
        phy.send(d, v, e);
        want.push_back(exp_word(port_mode, d, v, e));
    endtask : send

    always @(posedge ref_clk)
    begin
        if (rx_word_valid === 1'b1 && rx_word_ready === 1'b1)
            got.push_back(rx_word);
        if (rx_overrun === 1'b1)
            n_over++;
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            print_verdict();
        end
    end

    initial
    begin
        sys_rst = 1'b1;
        port_mode = MODE_MII;
        phy_emulation = 1'b0;
        carrier_sense_in = 1'b0;
        tx_frame_request = 1'b0;
        rx_word_ready = 1'b1;
        // Third pass stalls the reader so the buffer fills and refuses
        for (int k = 0; k < 3; k++)
        begin
            start(k == 1 ? MODE_RMII : MODE_MII, 1'b0);
            rx_word_ready = (k != 2);
            repeat (6) send(8'(rnd()), 1'b1, 1'b0);
            send(8'h5e, 1'b0, 1'b1);
            send(8'h57, 1'b1, 1'b1);
            phy.idle();
            tick(60);
            rx_word_ready = 1'b1;
            tick(60);
            if (k == 2)
                want = want[0:4];
            if (k == 2)
                check("overruns", n_over, 32'd3);
            check("word count", got.size(), want.size());
            foreach (want[i])
                check("rx word", 32'(got[i]), 32'(want[i]));
        end
        for (int k = 0; k < 4; k++)
        begin
            start(tm[k], tp[k]);
            check("clock oe", mii_transmit_clock_oe, tp[k] && tm[k] == MODE_MII);
            check("carrier oe", carrier_sense_oe, tp[k] && tm[k] != MODE_TBI);
            tx_frame_request = 1'b1;
            carrier_sense_in = 1'b1;
            if (k == 3)
                phy.send(8'ha5, 1'b0, 1'b1);
            tick(80);
            check("tx enable", tx_frame_enable, tm[k] != MODE_TBI);
            check("carrier", carrier_sensed, 1'b1);
            if (k == 3)
                check("tbi word", 32'(got[$]), {4'h8, 10'h2a5, 10'h2a5});
            tx_frame_request = 1'b0;
            carrier_sense_in = 1'b0;
            tick(24);
            check("tx enable off", tx_frame_enable, 1'b0);
            carrier_sense_in = 1'b1;
            #5 carrier_sense_in = 1'b0;
            tick(8);
            check("carrier glitch", carrier_sensed, 1'b0);
        end
        print_verdict();
    end
endmodule : mac_port_front_tb
